// *** inc/fbpg_pkg.sv ***
// Constants shared by the two-port GPIO block and its pin cell
package fbpg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index
    localparam logic [11:0] FBPG_IDX_P0_LATCH  = 12'h0000;
    localparam logic [11:0] FBPG_IDX_P1_LATCH  = 12'h0001;
    localparam logic [11:0] FBPG_IDX_P0_PINRD  = 12'h000D;
    localparam logic [11:0] FBPG_IDX_P1_PINRD  = 12'h000E;
    localparam logic [11:0] FBPG_IDX_P0_DIR    = 12'h0F1A;
    localparam logic [11:0] FBPG_IDX_P1_DIR    = 12'h0F1B;
    localparam logic [11:0] FBPG_IDX_P0_PULLUP = 12'h0F27;
    localparam logic [11:0] FBPG_IDX_P0_FUNC   = 12'h0F34;
    localparam logic [11:0] FBPG_IDX_SYSCTL    = 12'h0F80;
    localparam logic [11:0] FBPG_IDX_P1_PULLUP = 12'h0F81;

    ////////////////////////////////////////////////////////////////////////
    // Bus and field geometry
    localparam int          FBPG_ADDR_W      = 14;
    localparam int          FBPG_DATA_W      = 32;
    localparam int          FBPG_PORT_W      = 4;
    localparam int          FBPG_FS_HF_BIT   = 0;
    localparam int          FBPG_FS_LF_BIT   = 2;
    localparam int          FBPG_SC_OSC_BIT  = 0;
    localparam int          FBPG_SC_RSTF_BIT = 1;
    localparam int          FBPG_P1_RST_PIN  = 0;
    localparam int          FBPG_P1_STOP_PIN = 1;
    localparam int          FBPG_P1_IRQA_PIN = 2;
    localparam int          FBPG_P1_IRQB_PIN = 3;
    localparam int          FBPG_P1_IRQC_PIN = 1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [3:0]  FBPG_RST_NIBBLE  = 4'h0;
    localparam logic        FBPG_RST_FS_BIT  = 1'b0;
    localparam logic        FBPG_RST_OSC_EN  = 1'b0;
    localparam logic        FBPG_RST_RSTFUNC = 1'b1;
    localparam logic [31:0] FBPG_RD_ZERO     = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        FBPG_IDLE = 2'b01,
        FBPG_DONE = 2'b10
    } fbpg_bus_st_t;

endpackage

// *** logic/fbpg_pin.sv ***
// One port pin cell: drive, enable, pull-up and masked read value
module fbpg_pin
    import fbpg_pkg::*;
(
    input  wire logic mclk,      // System clock
    input  wire logic rst,       // Async reset, active high
    input  wire logic clk_en,    // Freezes state while low
    input  wire logic dir,       // 1 output, 0 input
    input  wire logic latch,     // Output latch bit
    input  wire logic pu_en,     // Pull-up request bit
    input  wire logic alt_sel,   // Pin taken by a secondary function
    input  wire logic pin_in,    // Live pin level
    output logic      pin_out_q, // Pin drive value
    output logic      pin_oe_q,  // Pin output enable
    output logic      pull_q,    // Pull-up connect
    output logic      read_val   // Masked pin level for reads
);

    ////////////////////////////////////////////////////////////////////////
    // Drive and enable, only in port output mode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end else if (clk_en) begin
            pin_out_q <= latch;
            pin_oe_q  <= dir & ~alt_sel;
        end
    end

    // Pull-up only while the pin is an input
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pull_q <= 1'b0;
        end else if (clk_en) begin
            pull_q <= pu_en & ~dir & ~alt_sel;
        end
    end

    // Zero when output or owned by a secondary function
    assign read_val = pin_in & ~dir & ~alt_sel;

endmodule

// *** logic/fbpg_top.sv ***
// Two 4-bit GPIO ports with crystal, interrupt and reset pin sharing
//
// Operation
// - Port 0 has four pins whose direction bits pick input (0) or output (1), reset to input.
// - A port 0 latch bit drives its pin low or high only in output mode, resets to 0, upper bits read 0.
// - Function bit 0 hands pins 0 and 1 to the high-frequency crystal and bit 2 pins 2 and 3 to the low one.
// - Setting the oscillator enable while the high-frequency select is 0 raises a system reset.
// - A port 0 pull-up bit connects the pull-up only when it is 1 and the pin is an input.
// - Pin read bits 0 and 1 give 0 in output mode or with the high-frequency crystal, else the pin level.
// - Pin read bits 2 and 3 give 0 in output mode or with the low-frequency crystal, else the pin level.
// - Port 1 has four pins with latch and direction registers, resetting to input and 0.
// - After reset port 1 pin 0 is the external reset input until software frees it for port use.
// - In input mode port 1 pins 3, 2 and 1 feed external interrupts, and pin 1 also the stop release.
// - Port 1 pull-ups can only be connected while their pin is an input.
// - Port 1 pin read gives 0 for output bits and for pin 0 while it holds the reset function, else the pin level.
module fbpg_top
    import fbpg_pkg::*;
(
    input  wire logic                   mclk,              // System clock
    input  wire logic                   rst,               // Async reset
    input  wire logic                   clk_en,            // Clock enable
    // Avalon-MM slave
    input  wire logic [FBPG_ADDR_W-1:0] address,           // Byte address
    input  wire logic                   read,              // Read request
    input  wire logic                   write,             // Write request
    input  wire logic [3:0]             byteenable,        // Byte lanes
    input  wire logic [FBPG_DATA_W-1:0] writedata,         // Write data
    output logic      [FBPG_DATA_W-1:0] readdata,          // Read data
    output logic                        waitrequest,       // Stall
    // Port 0 pins
    input  wire logic [3:0]             p0_pin_in,         // Pin levels
    output logic      [3:0]             p0_pin_out,        // Drive values
    output logic      [3:0]             p0_pin_oe,         // Drive enables
    output logic      [3:0]             p0_pullup_on,      // Pull-ups
    // Port 1 pins
    input  wire logic [3:0]             p1_pin_in,         // Pin levels
    output logic      [3:0]             p1_pin_out,        // Drive values
    output logic      [3:0]             p1_pin_oe,         // Drive enables
    output logic      [3:0]             p1_pullup_on,      // Pull-ups
    // Secondary functions
    output logic                        hf_crystal_select, // HF on pins 0/1
    output logic                        lf_crystal_select, // LF on pins 2/3
    output logic                        ext_hf_osc_enable, // HF osc enable
    output logic                        sys_reset_req,     // Reset pulse
    output logic                        ext_reset_n,       // Ext reset in
    output logic                        ext_irq_a,         // From pin 2
    output logic                        ext_irq_b,         // From pin 3
    output logic                        ext_irq_c,         // From pin 1
    output logic                        stop_release       // From pin 1
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [3:0]   p0_latch_q;
    logic [3:0]   p1_latch_q;
    logic [3:0]   p0_dir_q;
    logic [3:0]   p1_dir_q;
    logic [3:0]   p0_pu_q;
    logic [3:0]   p1_pu_q;
    logic         hf_sel_q;
    logic         lf_sel_q;
    logic         osc_en_q;
    logic         rst_func_q;
    logic         sys_rst_q;
    logic         irq_a_q;
    logic         irq_b_q;
    logic         irq_c_q;
    logic         stop_q;
    logic         ext_rst_n_q;
    logic [31:0]  rdata_q;
    logic         wait_q;
    fbpg_bus_st_t st_q;

    // Pin cell ownership inputs and read outputs
    logic [3:0]   p0_alt;
    logic [3:0]   p1_alt;
    logic [3:0]   p0_rd;
    logic [3:0]   p1_rd;

    // Bus decode
    logic [11:0]  idx;
    logic         req;
    logic         wr_go;
    logic         lane0;
    logic [7:0]   wbyte;

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // Register hit on the word index
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] r);
        hit = (a == r);
    endfunction

    // Low nibble of a byte, upper bits dropped
    function automatic logic [3:0] nib(input logic [7:0] b);
        nib = b[3:0];
    endfunction

    // Index, request and write-commit decode
    assign idx   = address[FBPG_ADDR_W-1:2];
    assign req   = read | write;
    assign wr_go = write & (st_q == FBPG_DONE);
    assign lane0 = byteenable[0];
    assign wbyte = writedata[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: accept, then release with one low waitrequest cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q   <= FBPG_IDLE;
            wait_q <= 1'b1;
        end else if (clk_en) begin
            case (st_q)
                FBPG_IDLE: begin
                    if (req) begin
                        st_q   <= FBPG_DONE;
                        wait_q <= 1'b0;
                    end
                end
                FBPG_DONE: begin
                    st_q   <= FBPG_IDLE;
                    wait_q <= 1'b1;
                end
                default: begin
                    st_q   <= FBPG_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured when the answer is issued
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= FBPG_RD_ZERO;
        end else if (clk_en) begin
            if (read && st_q == FBPG_IDLE) begin
                // Unmapped indices answer zero
                rdata_q <= FBPG_RD_ZERO;
                if (hit(idx, FBPG_IDX_P0_LATCH)) begin
                    rdata_q[3:0] <= p0_latch_q;
                end else if (hit(idx, FBPG_IDX_P1_LATCH)) begin
                    rdata_q[3:0] <= p1_latch_q;
                end else if (hit(idx, FBPG_IDX_P0_PINRD)) begin
                    rdata_q[3:0] <= p0_rd;
                end else if (hit(idx, FBPG_IDX_P1_PINRD)) begin
                    rdata_q[3:0] <= p1_rd;
                end else if (hit(idx, FBPG_IDX_P0_DIR)) begin
                    rdata_q[3:0] <= p0_dir_q;
                end else if (hit(idx, FBPG_IDX_P1_DIR)) begin
                    rdata_q[3:0] <= p1_dir_q;
                end else if (hit(idx, FBPG_IDX_P0_PULLUP)) begin
                    rdata_q[3:0] <= p0_pu_q;
                end else if (hit(idx, FBPG_IDX_P1_PULLUP)) begin
                    rdata_q[3:0] <= p1_pu_q;
                end else if (hit(idx, FBPG_IDX_P0_FUNC)) begin
                    rdata_q[FBPG_FS_HF_BIT] <= hf_sel_q;
                    rdata_q[FBPG_FS_LF_BIT] <= lf_sel_q;
                end else if (hit(idx, FBPG_IDX_SYSCTL)) begin
                    rdata_q[FBPG_SC_OSC_BIT]  <= osc_en_q;
                    rdata_q[FBPG_SC_RSTF_BIT] <= rst_func_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port 0 latch and direction
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            p0_latch_q <= FBPG_RST_NIBBLE;
            p0_dir_q   <= FBPG_RST_NIBBLE;
        end else if (clk_en && wr_go && lane0) begin
            if (hit(idx, FBPG_IDX_P0_LATCH)) begin
                p0_latch_q <= nib(wbyte);
            end
            if (hit(idx, FBPG_IDX_P0_DIR)) begin
                p0_dir_q <= nib(wbyte);
            end
        end
    end

    // Port 0 pull-up and function select
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            p0_pu_q  <= FBPG_RST_NIBBLE;
            hf_sel_q <= FBPG_RST_FS_BIT;
            lf_sel_q <= FBPG_RST_FS_BIT;
        end else if (clk_en && wr_go && lane0) begin
            if (hit(idx, FBPG_IDX_P0_PULLUP)) begin
                p0_pu_q <= nib(wbyte);
            end
            if (hit(idx, FBPG_IDX_P0_FUNC)) begin
                hf_sel_q <= wbyte[FBPG_FS_HF_BIT];
                lf_sel_q <= wbyte[FBPG_FS_LF_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port 1 latch, direction and pull-up
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            p1_latch_q <= FBPG_RST_NIBBLE;
            p1_dir_q   <= FBPG_RST_NIBBLE;
            p1_pu_q    <= FBPG_RST_NIBBLE;
        end else if (clk_en && wr_go && lane0) begin
            if (hit(idx, FBPG_IDX_P1_LATCH)) begin
                p1_latch_q <= nib(wbyte);
            end
            if (hit(idx, FBPG_IDX_P1_DIR)) begin
                p1_dir_q <= nib(wbyte);
            end
            if (hit(idx, FBPG_IDX_P1_PULLUP)) begin
                p1_pu_q <= nib(wbyte);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System control: oscillator enable and reset-pin function
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            osc_en_q   <= FBPG_RST_OSC_EN;
            rst_func_q <= FBPG_RST_RSTFUNC;
            sys_rst_q  <= 1'b0;
        end else if (clk_en) begin
            // Reset request lasts one cycle
            sys_rst_q <= 1'b0;
            if (wr_go && lane0 && hit(idx, FBPG_IDX_SYSCTL)) begin
                // Software frees pin 0 for port use
                rst_func_q <= wbyte[FBPG_SC_RSTF_BIT];
                if (wbyte[FBPG_SC_OSC_BIT] && !hf_sel_q) begin
                    sys_rst_q <= 1'b1;
                    osc_en_q  <= 1'b0;
                end else begin
                    osc_en_q <= wbyte[FBPG_SC_OSC_BIT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Secondary-function ownership per pin
    // Crystal owns pins regardless of direction
    assign p0_alt = {lf_sel_q, lf_sel_q, hf_sel_q, hf_sel_q};
    // Reset function owns port 1 pin 0
    assign p1_alt = {3'b000, rst_func_q};

    // Pin cells for both ports
    genvar gi;
    generate
        for (gi = 0; gi < FBPG_PORT_W; gi++) begin : g_pin
            fbpg_pin u_p0 (
                .mclk      (mclk),
                .rst       (rst),
                .clk_en    (clk_en),
                .dir       (p0_dir_q[gi]),
                .latch     (p0_latch_q[gi]),
                .pu_en     (p0_pu_q[gi]),
                .alt_sel   (p0_alt[gi]),
                .pin_in    (p0_pin_in[gi]),
                .pin_out_q (p0_pin_out[gi]),
                .pin_oe_q  (p0_pin_oe[gi]),
                .pull_q    (p0_pullup_on[gi]),
                .read_val  (p0_rd[gi])
            );
            fbpg_pin u_p1 (
                .mclk      (mclk),
                .rst       (rst),
                .clk_en    (clk_en),
                .dir       (p1_dir_q[gi]),
                .latch     (p1_latch_q[gi]),
                .pu_en     (p1_pu_q[gi]),
                .alt_sel   (p1_alt[gi]),
                .pin_in    (p1_pin_in[gi]),
                .pin_out_q (p1_pin_out[gi]),
                .pin_oe_q  (p1_pin_oe[gi]),
                .pull_q    (p1_pullup_on[gi]),
                .read_val  (p1_rd[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupt, stop-release and reset inputs from port 1
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_a_q     <= 1'b0;
            irq_b_q     <= 1'b0;
            irq_c_q     <= 1'b0;
            stop_q      <= 1'b0;
            ext_rst_n_q <= 1'b1;
        end else if (clk_en) begin
            irq_a_q <= p1_pin_in[FBPG_P1_IRQA_PIN]
                       & ~p1_dir_q[FBPG_P1_IRQA_PIN];
            irq_b_q <= p1_pin_in[FBPG_P1_IRQB_PIN]
                       & ~p1_dir_q[FBPG_P1_IRQB_PIN];
            irq_c_q <= p1_pin_in[FBPG_P1_IRQC_PIN]
                       & ~p1_dir_q[FBPG_P1_IRQC_PIN];
            stop_q  <= p1_pin_in[FBPG_P1_STOP_PIN]
                       & ~p1_dir_q[FBPG_P1_STOP_PIN];
            // Pin level while reset function held
            ext_rst_n_q <= rst_func_q ? p1_pin_in[FBPG_P1_RST_PIN]
                                      : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign readdata          = rdata_q;
    assign waitrequest       = wait_q;
    assign hf_crystal_select = hf_sel_q;
    assign lf_crystal_select = lf_sel_q;
    assign ext_hf_osc_enable = osc_en_q;
    assign sys_reset_req     = sys_rst_q;
    assign ext_reset_n       = ext_rst_n_q;
    assign ext_irq_a         = irq_a_q;
    assign ext_irq_b         = irq_b_q;
    assign ext_irq_c         = irq_c_q;
    assign stop_release      = stop_q;

endmodule

// *** sim/fbpg_top_asserts.sv ***
// Checker on the GPIO block's ports, bound to its top
module fbpg_top_asserts
    import fbpg_pkg::*;
(
    input wire logic                   mclk,              // System clock
    input wire logic                   rst,               // Async reset
    input wire logic                   clk_en,            // Clock enable
    input wire logic                   read,              // Read request
    input wire logic                   write,             // Write request
    input wire logic [FBPG_DATA_W-1:0] readdata,          // Read data
    input wire logic                   waitrequest,       // Stall
    input wire logic [3:0]             p0_pin_oe,         // Port 0 enables
    input wire logic [3:0]             p0_pullup_on,      // Port 0 pull-ups
    input wire logic [3:0]             p1_pin_in,         // Port 1 levels
    input wire logic [3:0]             p1_pin_oe,         // Port 1 enables
    input wire logic [3:0]             p1_pullup_on,      // Port 1 pull-ups
    input wire logic                   hf_crystal_select, // HF crystal
    input wire logic                   lf_crystal_select, // LF crystal
    input wire logic                   ext_hf_osc_enable, // HF osc enable
    input wire logic                   sys_reset_req,     // Reset pulse
    input wire logic                   ext_reset_n,       // Ext reset in
    input wire logic                   ext_irq_a,         // From pin 2
    input wire logic                   ext_irq_b,         // From pin 3
    input wire logic                   ext_irq_c,         // From pin 1
    input wire logic                   stop_release       // From pin 1
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Bus request and its single-cycle answer
    sequence s_req;
        clk_en && (read || write) && waitrequest;
    endsequence
    sequence s_ack;
        !waitrequest ##1 waitrequest;
    endsequence
    bus_answer_a: assert property (s_req |=> s_ack)
        else $error("late bus answer");
    upper_zero_a: assert property (readdata[31:4] == 28'h000_0000)
        else $error("read data upper bits set");

    ////////////////////////////////////////////////////////////////////////
    // crystal owns pins, no pull-up on outputs
    hf_owns_a: assert property ($past(hf_crystal_select) &&
        hf_crystal_select |-> (p0_pin_oe[1:0] | p0_pullup_on[1:0]) == 2'h0)
        else $error("HF crystal pins in use");
    lf_owns_a: assert property ($past(lf_crystal_select) &&
        lf_crystal_select |-> (p0_pin_oe[3:2] | p0_pullup_on[3:2]) == 2'h0)
        else $error("LF crystal pins in use");
    p0_pull_a: assert property ((p0_pullup_on & p0_pin_oe) == 4'h0)
        else $error("port 0 pull-up on output");
    p1_pull_a: assert property ((p1_pullup_on & p1_pin_oe) == 4'h0)
        else $error("port 1 pull-up on output");

    ////////////////////////////////////////////////////////////////////////
    // bad enable pulse, reset pin and port 1 inputs
    osc_pulse_a: assert property (sys_reset_req |->
        (!hf_crystal_select && !ext_hf_osc_enable) ##1 !sys_reset_req)
        else $error("bad reset pulse");
    osc_guard_a: assert property ($rose(ext_hf_osc_enable)
        |-> hf_crystal_select)
        else $error("osc enabled without HF");
    ext_rst_a: assert property (!ext_reset_n |->
        !p1_pin_oe[0] && !p1_pullup_on[0])
        else $error("reset pin used as port");
    irq_follow_a: assert property (!$past(rst) && $past(clk_en) &&
        !p1_pin_oe[2] |-> ext_irq_a == $past(p1_pin_in[2]))
        else $error("irq a not following pin");
    irq_quiet_a: assert property (p1_pin_oe[3] |-> !ext_irq_b)
        else $error("irq b high in output mode");
    stop_pin_a: assert property (stop_release == ext_irq_c)
        else $error("stop release not pin 1");
endmodule

bind fbpg_top fbpg_top_asserts u_chk (.*);

// *** sim/fbpg_pins_model.sv ***
// Pin model for both ports: drive, outside driver, pull-up or floating
module fbpg_pins_model (
    input  wire logic       mclk,    // System clock
    input  wire logic [7:0] pin_out, // Drive values, port 1 high
    input  wire logic [7:0] pin_oe,  // Drive enables
    input  wire logic [7:0] pull_on, // Pull-up connects
    input  wire logic [7:0] ext_lvl, // Outside driver level
    input  wire logic [7:0] ext_en,  // Outside driver enable
    output logic      [7:0] pin_lvl  // Resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] float_q = 8'h55;

    // Undriven pins toggle each cycle
    always @(posedge mclk) begin
        float_q <= ~float_q;
    end
    // Device drive wins, then outside driver, then pull-up
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
                   | (~pin_oe & ~ext_en & (pull_on | float_q));
endmodule

// *** sim/tb.sv ***
// Register and pin tests of the two-port GPIO block
module tb
    import fbpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   mclk, rst, clk_en, read, write, waitrequest;
    logic [FBPG_ADDR_W-1:0] address;
    logic [3:0]             byteenable;
    logic [FBPG_DATA_W-1:0] writedata, readdata;
    logic [3:0]             p0_pin_out, p0_pin_oe, p0_pullup_on;
    logic [3:0]             p1_pin_out, p1_pin_oe, p1_pullup_on;
    logic                   hf_crystal_select, lf_crystal_select;
    logic                   ext_hf_osc_enable, sys_reset_req, ext_reset_n;
    logic                   ext_irq_a, ext_irq_b, ext_irq_c, stop_release;
    logic [7:0]             ext_lvl, ext_en, rdata;
    wire  [7:0]             pins;
    wire  [3:0]             p0_pin_in = pins[3:0];
    wire  [3:0]             p1_pin_in = pins[7:4];
    int                     error_cnt, total_checks, pulse_cnt = 0;

    fbpg_top u_dut (.*);
    fbpg_pins_model u_pins (.mclk, .pin_out({p1_pin_out, p0_pin_out}),
        .pin_oe({p1_pin_oe, p0_pin_oe}), .pull_on({p1_pullup_on,
        p0_pullup_on}), .ext_lvl, .ext_en, .pin_lvl(pins));

    ////////////////////////////////////////////////////////////////////////
    // Clock, reset pulse counter and hang guard (run is under 1000 cycles)
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (sys_reset_req === 1'b1) pulse_cnt <= pulse_cnt + 1;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        complete_run;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare, bus transfer and settle helpers
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Held until waitrequest is seen low at a rising edge
    task xfer(input logic w, input logic [11:0] idx, input logic [7:0] d,
              input logic [3:0] be);
        @(posedge mclk);
        address <= {idx, 2'b00};
        write <= w;
        read <= !w;
        writedata <= {24'h00_0000, d};
        byteenable <= be;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rdata = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task wr(input logic [11:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 4'h1);
    endtask
    task rd(input logic [11:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00, 4'h1);
        chk(rdata, exp);
    endtask
    task settle;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        {rst, clk_en, read, write} = 4'hC;
        {address, byteenable, writedata} = '0;
        ext_lvl = 8'h10;
        ext_en = 8'h10;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        // Reset values and an unmapped index
        rd(FBPG_IDX_P0_LATCH, 8'h00);
        rd(FBPG_IDX_P1_LATCH, 8'h00);
        rd(FBPG_IDX_P0_DIR, 8'h00);
        rd(FBPG_IDX_P1_DIR, 8'h00);
        rd(FBPG_IDX_P0_PULLUP, 8'h00);
        rd(FBPG_IDX_P0_FUNC, 8'h00);
        rd(12'h123, 8'h00);
        $display("test 1 done");
        // Port 0 outputs, ignored upper bits and lane
        wr(FBPG_IDX_P0_DIR, 8'hFF);
        rd(FBPG_IDX_P0_DIR, 8'h0F);
        wr(FBPG_IDX_P0_LATCH, 8'hA5);
        xfer(1'b1, FBPG_IDX_P0_LATCH, 8'hFF, 4'h0);
        rd(FBPG_IDX_P0_LATCH, 8'h05);
        settle;
        chk({4'h0, p0_pin_oe}, 8'h0F);
        chk({4'h0, p0_pin_out}, 8'h05);
        rd(FBPG_IDX_P0_PINRD, 8'h00);
        $display("test 2 done");
        // Port 0 inputs and pull-ups
        wr(FBPG_IDX_P0_DIR, 8'h00);
        wr(FBPG_IDX_P0_PULLUP, 8'hFF);
        rd(FBPG_IDX_P0_PULLUP, 8'h0F);
        settle;
        chk({4'h0, p0_pullup_on}, 8'h0F);
        rd(FBPG_IDX_P0_PINRD, 8'h0F);
        ext_en <= 8'h1C;
        ext_lvl <= 8'h14;
        wr(FBPG_IDX_P0_DIR, 8'h03);
        settle;
        chk({4'h0, p0_pullup_on}, 8'h0C);
        rd(FBPG_IDX_P0_PINRD, 8'h04);
        $display("test 3 done");
        // Crystal functions, direction kept at input
        wr(FBPG_IDX_P0_DIR, 8'h00);
        ext_en <= 8'h1F;
        ext_lvl <= 8'h1F;
        wr(FBPG_IDX_P0_FUNC, 8'hFF);
        rd(FBPG_IDX_P0_FUNC, 8'h05);
        settle;
        chk({6'h00, lf_crystal_select, hf_crystal_select}, 8'h03);
        chk({p0_pin_oe, p0_pullup_on}, 8'h00);
        rd(FBPG_IDX_P0_PINRD, 8'h00);
        wr(FBPG_IDX_P0_FUNC, 8'h04);
        rd(FBPG_IDX_P0_PINRD, 8'h03);
        $display("test 4 done");
        // Oscillator enable before and after the HF select
        wr(FBPG_IDX_P0_FUNC, 8'h00);
        wr(FBPG_IDX_SYSCTL, 8'h03);
        settle;
        chk(pulse_cnt[7:0], 8'h01);
        chk({7'h00, ext_hf_osc_enable}, 8'h00);
        wr(FBPG_IDX_P0_FUNC, 8'h01);
        wr(FBPG_IDX_SYSCTL, 8'h03);
        settle;
        chk(pulse_cnt[7:0], 8'h01);
        chk({7'h00, ext_hf_osc_enable}, 8'h01);
        $display("test 5 done");
        // Port 1 reset pin, interrupts, outputs and reads
        ext_en <= 8'hF0;
        ext_lvl <= 8'hF0;
        rd(FBPG_IDX_P1_PINRD, 8'h0E);
        ext_lvl <= 8'hE0;
        settle;
        chk({7'h00, ext_reset_n}, 8'h00);
        chk({5'h00, ext_irq_b, ext_irq_a, ext_irq_c}, 8'h07);
        wr(FBPG_IDX_SYSCTL, 8'h00);
        ext_lvl <= 8'hF0;
        settle;
        chk({7'h00, ext_reset_n}, 8'h01);
        rd(FBPG_IDX_P1_PINRD, 8'h0F);
        ext_en <= 8'h50;
        wr(FBPG_IDX_P1_DIR, 8'hFA);
        rd(FBPG_IDX_P1_DIR, 8'h0A);
        wr(FBPG_IDX_P1_LATCH, 8'h0F);
        wr(FBPG_IDX_P1_PULLUP, 8'h0F);
        settle;
        chk({p1_pin_oe, p1_pin_out}, 8'hAF);
        chk({4'h0, p1_pullup_on}, 8'h05);
        rd(FBPG_IDX_P1_PINRD, 8'h05);
        chk({5'h00, ext_irq_b, ext_irq_a, ext_irq_c}, 8'h02);
        chk({7'h00, stop_release}, 8'h00);
        $display("test 6 done");
        complete_run;
    end
endmodule
